// ==== src/scp_cmd.sv ====
/*
  Serial register command interpreter: uart receiver and transmitter,
  packet parser and checker, byte-wise register access port, response
  builder.
  Assumes the register side answers each byte request with reg_ack.
*/
`timescale 1ns/1ps
module scp_cmd #(
  parameter int MAX_DATA = 16,               // largest register payload in bytes
  parameter int BIT_CYC  = scp_pkg::BIT_CYC  // core cycles per serial bit
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  ser_rx,
  output      logic                  ser_tx,
  output      scp_pkg::scp_reg_cmd_s reg_cmd,
  input  wire logic [7:0]            reg_rdata,
  input  wire logic                  reg_ack,
  output      logic                  pkt_drop
);

  // ------------------------------------------------------------------
  // receive pin synchroniser
  // ------------------------------------------------------------------
  logic        rx_s1, rx_s2, rx_s3, rx_lvl;
  // a change counts once second and third stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_s1  <= 1'b1;
      rx_s2  <= 1'b1;
      rx_s3  <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      rx_s1 <= ser_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_lvl <= rx_s3;
    end
  end

  // ------------------------------------------------------------------
  // uart receiver
  // ------------------------------------------------------------------
  logic        rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_vld;
  logic [7:0]  rx_byte;
  // start edge, half-bit check, eight data bits, stop bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_cnt  <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_sh   <= 8'h00;
      rx_vld  <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_vld <= 1'b0;
      if (!rx_busy) begin
        if (!rx_lvl) begin
          rx_busy <= 1'b1;
          rx_cnt  <= 16'(BIT_CYC / 2 - 1);
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= 16'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (rx_lvl) rx_busy <= 1'b0;          // false start
        end else if (rx_bit <= 4'(scp_pkg::DATA_BITS)) begin
          rx_sh <= {rx_lvl, rx_sh[7:1]};
        end else begin
          rx_busy <= 1'b0;
          rx_vld  <= rx_lvl;                    // no parity, stop must be high
          rx_byte <= rx_sh;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // uart transmitter
  // ------------------------------------------------------------------
  logic        tx_go;
  logic [7:0]  tx_data;
  logic        tx_busy;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [9:0]  tx_sh;
  // start bit, eight data bits lsb first, stop bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_cnt  <= 16'h0000;
      tx_bit  <= 4'h0;
      tx_sh   <= 10'h3FF;
      ser_tx  <= 1'b1;
    end else if (!tx_busy) begin
      ser_tx <= 1'b1;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, tx_data, 1'b0};
        tx_cnt  <= 16'h0000;
        tx_bit  <= 4'h0;
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else if (tx_bit == 4'hA) begin
      tx_busy <= 1'b0;
    end else begin
      ser_tx <= tx_sh[0];
      tx_sh  <= {1'b1, tx_sh[9:1]};
      tx_bit <= tx_bit + 4'h1;
      tx_cnt <= 16'(BIT_CYC - 1);
    end
  end

  // ------------------------------------------------------------------
  // packet state
  // ------------------------------------------------------------------
  scp_pkg::scp_state_e state;
  logic [15:0] idx;                 // byte index in packet
  logic [7:0]  hdr [16];
  logic [7:0]  buf_mem [MAX_DATA];
  logic [63:0] addr;
  logic [15:0] rd_len;
  logic [15:0] crc_run, crc_hdr;
  logic [15:0] acc_idx, acc_len;
  logic        is_rd, resp;

  // header fields, most significant byte first
  wire  [15:0] f_hchk  = {hdr[2], hdr[3]};
  wire  [15:0] f_pchk  = {hdr[4], hdr[5]};
  wire  [15:0] f_chan  = {hdr[6], hdr[7]};
  wire  [15:0] f_flags = {hdr[8], hdr[9]};
  wire  [15:0] f_cmd   = {hdr[10], hdr[11]};
  wire  [15:0] f_dlen  = {hdr[12], hdr[13]};
  wire  [15:0] f_seq   = {hdr[14], hdr[15]};
  wire  [15:0] max_d   = 16'(MAX_DATA);

  // receive-side decode
  wire         rx_take  = (state == scp_pkg::ST_RECV) && rx_vld;
  wire         pfx_bad  = ((idx == 16'h0000) && (rx_byte != scp_pkg::PREFIX_0)) ||
                          ((idx == 16'h0001) && (rx_byte != scp_pkg::PREFIX_1));
  wire  [15:0] ded_idx  = idx - scp_pkg::HDR_LEN;
  wire  [15:0] wr_idx   = ded_idx - scp_pkg::ADDR_BYTES;
  wire         pkt_last = (idx >= scp_pkg::HDR_LAST) &&
                          (idx == scp_pkg::HDR_LAST + f_dlen);
  wire         hdr_done = (idx == scp_pkg::HDR_LAST);
  wire  [15:0] crc_rx   = scp_pkg::crc16_byte(crc_run, rx_byte);

  // packet acceptance
  wire         chk_ok   = (crc_hdr == f_hchk) && (crc_run == f_pchk);
  wire         chan_ok  = (f_chan == 16'h0000);
  wire         flag_ok  = (f_flags == scp_pkg::FLAG_RESP) ||
                          (f_flags == scp_pkg::FLAG_NORESP);
  wire         rd_ok    = (f_cmd == scp_pkg::CMD_READ) && (f_dlen == scp_pkg::RD_DED_LEN) &&
                          (rd_len != 16'h0000) && (rd_len <= max_d);
  wire         wr_ok    = (f_cmd == scp_pkg::CMD_WRITE) &&
                          (f_dlen > scp_pkg::ADDR_BYTES) &&
                          (f_dlen <= scp_pkg::ADDR_BYTES + max_d);
  wire         pkt_ok   = chk_ok && chan_ok && flag_ok && (rd_ok || wr_ok);

  // response layout
  wire  [15:0] resp_len = is_rd ? acc_len : scp_pkg::WR_ACK_LEN;
  wire  [15:0] tx_total = scp_pkg::HDR_LEN + resp_len;
  wire  [15:0] ack_cmd  = is_rd ? scp_pkg::CMD_READ_ACK : scp_pkg::CMD_WRITE_ACK;
  wire  [15:0] tx_didx  = idx - scp_pkg::HDR_LEN;
  logic [7:0]  tx_byte;

  // response byte at position idx
  always_comb begin
    case (idx)
      16'h0000: tx_byte = scp_pkg::PREFIX_0;
      16'h0001: tx_byte = scp_pkg::PREFIX_1;
      16'h0002: tx_byte = crc_hdr[15:8];
      16'h0003: tx_byte = crc_hdr[7:0];
      16'h0004: tx_byte = crc_run[15:8];
      16'h0005: tx_byte = crc_run[7:0];
      16'h0006: tx_byte = 8'h00;
      16'h0007: tx_byte = 8'h00;
      16'h0008: tx_byte = scp_pkg::FLAG_OK[15:8];
      16'h0009: tx_byte = scp_pkg::FLAG_OK[7:0];
      16'h000A: tx_byte = ack_cmd[15:8];
      16'h000B: tx_byte = ack_cmd[7:0];
      16'h000C: tx_byte = resp_len[15:8];
      16'h000D: tx_byte = resp_len[7:0];
      16'h000E: tx_byte = f_seq[15:8];
      16'h000F: tx_byte = f_seq[7:0];
      default:  tx_byte = is_rd ? buf_mem[tx_didx[$clog2(MAX_DATA)-1:0]] : 8'h00;
    endcase
  end

  wire  [15:0] crc_tx  = scp_pkg::crc16_byte(crc_run, tx_byte);
  wire         acc_end = (acc_idx == acc_len - 16'h0001);
  // register access port, one byte per handshake
  assign reg_cmd.req   = (state == scp_pkg::ST_ACCESS);
  assign reg_cmd.we    = !is_rd;
  assign reg_cmd.addr  = addr;
  assign reg_cmd.idx   = acc_idx;
  assign reg_cmd.wdata = buf_mem[acc_idx[$clog2(MAX_DATA)-1:0]];
  assign tx_data       = tx_byte;

  // ------------------------------------------------------------------
  // packet sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= scp_pkg::ST_RECV;
      idx      <= 16'h0000;
      addr     <= 64'h0;
      rd_len   <= 16'h0000;
      crc_run  <= scp_pkg::CRC_INIT;
      crc_hdr  <= scp_pkg::CRC_INIT;
      acc_idx  <= 16'h0000;
      acc_len  <= 16'h0000;
      is_rd    <= 1'b0;
      resp     <= 1'b0;
      tx_go    <= 1'b0;
      pkt_drop <= 1'b0;
      for (int i = 0; i < 16; i++) hdr[i] <= 8'h00;
      for (int i = 0; i < MAX_DATA; i++) buf_mem[i] <= 8'h00;
    end else begin
      tx_go    <= 1'b0;
      pkt_drop <= 1'b0;
      case (state)
        scp_pkg::ST_RECV: begin
          if (rx_take) begin
            if (pfx_bad) begin
              idx <= 16'h0000;
            end else begin
              idx <= idx + 16'h0001;
              if (idx < scp_pkg::HDR_LEN) hdr[idx[3:0]] <= rx_byte;
              if (idx == 16'h0000) crc_run <= scp_pkg::CRC_INIT;
              if (idx >= scp_pkg::CHK_START) crc_run <= crc_rx;
              if (hdr_done) crc_hdr <= crc_rx;
              if ((idx >= scp_pkg::HDR_LEN) && (ded_idx < scp_pkg::ADDR_BYTES))
                addr <= {addr[55:0], rx_byte};
              if ((ded_idx >= scp_pkg::ADDR_BYTES) && (idx >= scp_pkg::HDR_LEN)) begin
                rd_len <= {rd_len[7:0], rx_byte};
                if (wr_idx < max_d) buf_mem[wr_idx[$clog2(MAX_DATA)-1:0]] <= rx_byte;
              end
              if (pkt_last) state <= scp_pkg::ST_CHECK;
            end
          end
        end
        scp_pkg::ST_CHECK: begin
          idx     <= 16'h0000;
          acc_idx <= 16'h0000;
          is_rd   <= (f_cmd == scp_pkg::CMD_READ);
          resp    <= (f_flags == scp_pkg::FLAG_RESP);
          acc_len <= (f_cmd == scp_pkg::CMD_READ) ? rd_len : f_dlen - scp_pkg::ADDR_BYTES;
          if (pkt_ok) begin
            state <= scp_pkg::ST_ACCESS;
          end else begin
            state    <= scp_pkg::ST_RECV;
            pkt_drop <= 1'b1;
          end
        end
        scp_pkg::ST_ACCESS: begin
          if (reg_ack) begin
            if (is_rd) buf_mem[acc_idx[$clog2(MAX_DATA)-1:0]] <= reg_rdata;
            acc_idx <= acc_idx + 16'h0001;
            if (acc_end) begin
              idx     <= scp_pkg::CHK_START;
              crc_run <= scp_pkg::CRC_INIT;
              state   <= resp ? scp_pkg::ST_CALC : scp_pkg::ST_RECV;
              if (!resp) idx <= 16'h0000;
            end
          end
        end
        scp_pkg::ST_CALC: begin
          crc_run <= crc_tx;
          if (idx == scp_pkg::HDR_LAST) crc_hdr <= crc_tx;
          if (idx == tx_total - 16'h0001) begin
            idx   <= 16'h0000;
            state <= scp_pkg::ST_SEND;
          end else begin
            idx <= idx + 16'h0001;
          end
        end
        scp_pkg::ST_SEND: begin
          if (tx_go) idx <= idx + 16'h0001;          // step only once the byte is loaded
          if (!tx_busy && !tx_go) begin
            if (idx == tx_total) begin
              idx   <= 16'h0000;
              state <= scp_pkg::ST_RECV;
            end else begin
              tx_go <= 1'b1;
            end
          end
        end
        default: state <= scp_pkg::ST_RECV;
      endcase
    end
  end

endmodule : scp_cmd

// ==== src/scp_pkg.sv ====
/*
  Constants, carrier types and the check-word function of the serial
  register command interpreter.
  Assumes one 100 MHz core clock; nothing else is shared.
*/
package scp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ    = 100_000_000;
  localparam int BAUD_RATE = 115200;
  localparam int BIT_CYC   = CLK_HZ / BAUD_RATE;   // cycles per bit
  localparam int HALF_CYC  = BIT_CYC / 2;
  localparam int DATA_BITS = 8;

  // ------------------------------------------------------------------
  // packet layout and codes
  // ------------------------------------------------------------------
  localparam logic [7:0]  PREFIX_0      = 8'h01;
  localparam logic [7:0]  PREFIX_1      = 8'h00;
  localparam logic [15:0] HDR_LEN       = 16'h0010;
  localparam logic [15:0] CHK_START     = 16'h0006; // first checked byte
  localparam logic [15:0] HDR_LAST      = 16'h000F;
  localparam logic [15:0] FLAG_RESP     = 16'h4001;
  localparam logic [15:0] FLAG_NORESP   = 16'h0001;
  localparam logic [15:0] FLAG_OK       = 16'h0000;
  localparam logic [15:0] CMD_READ      = 16'h0800;
  localparam logic [15:0] CMD_READ_ACK  = 16'h0801;
  localparam logic [15:0] CMD_WRITE     = 16'h0802;
  localparam logic [15:0] CMD_WRITE_ACK = 16'h0803;
  localparam logic [15:0] RD_DED_LEN    = 16'h000C;
  localparam logic [15:0] ADDR_BYTES    = 16'h0008;
  localparam logic [15:0] WR_ACK_LEN    = 16'h0004;

  // ------------------------------------------------------------------
  // check word
  // ------------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // one byte folded into the running check word, msb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
                                             input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc16_byte

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        req;    // access pending until ack
    logic        we;     // 1 write, 0 read
    logic [63:0] addr;   // register address
    logic [15:0] idx;    // byte index within the register
    logic [7:0]  wdata;  // byte to write
  } scp_reg_cmd_s;

  typedef enum logic [4:0] {
    ST_RECV   = 5'b00001,
    ST_CHECK  = 5'b00010,
    ST_ACCESS = 5'b00100,
    ST_CALC   = 5'b01000,
    ST_SEND   = 5'b10000
  } scp_state_e;

endpackage : scp_pkg

// ==== sim/scp_cmd_checker.sv ====
/*
  Port checker of the serial register command interpreter.
  Assumes it is bound into scp_cmd and sees only its ports.
*/
`timescale 1ns/1ps
module scp_cmd_checker #(
  parameter int MAX_DATA = 16,
  parameter int BIT_CYC  = scp_pkg::BIT_CYC
) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  ser_rx,
  input wire logic                  ser_tx,
  input wire scp_pkg::scp_reg_cmd_s reg_cmd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_ack,
  input wire logic                  pkt_drop
);
  localparam int BIT = BIT_CYC;
  int lo_cnt;
  int hi_cnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // run lengths of the serial output levels, high run saturates
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= ser_tx ? 0 : lo_cnt + 1;
      hi_cnt <= !ser_tx ? 0 : ((hi_cnt < BIT) ? hi_cnt + 1 : hi_cnt);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_quiet_a: assert property ($fell(rst) |-> ser_tx && !reg_cmd.req && !pkt_drop)
    else $error("outputs not idle after reset");
  low_run_a: assert property ($rose(ser_tx) |-> lo_cnt != 0 && lo_cnt % BIT == 0)
    else $error("low level not whole bit times");
  stop_gap_a: assert property ($fell(ser_tx) |-> hi_cnt >= BIT)
    else $error("start bit without full stop time");
  drop_pulse_a: assert property (pkt_drop |=> !pkt_drop)
    else $error("discard pulse longer than one cycle");
  drop_noacc_a: assert property (pkt_drop |=> !reg_cmd.req [*8])
    else $error("register access after discard");
  req_hold_a: assert property (reg_cmd.req && !reg_ack |=> reg_cmd.req && $stable(reg_cmd))
    else $error("access request changed before ack");
  idx_step_a: assert property (reg_cmd.req && reg_ack |=>
      !reg_cmd.req || reg_cmd.idx == $past(reg_cmd.idx) + 16'h0001)
    else $error("byte index did not step by one");
  idx_range_a: assert property (reg_cmd.req |-> reg_cmd.idx < MAX_DATA)
    else $error("byte index beyond payload limit");
  tx_idle_acc_a: assert property (reg_cmd.req |-> ser_tx)
    else $error("transmit during register access");

  cover property (pkt_drop);
  cover property (reg_cmd.req && reg_ack && reg_cmd.we);
  cover property (reg_cmd.req && reg_ack && !reg_cmd.we);
  cover property ($fell(ser_tx));
endmodule : scp_cmd_checker

bind scp_cmd scp_cmd_checker #(.MAX_DATA(MAX_DATA), .BIT_CYC(BIT_CYC)) chk_u (
  .core_clk(core_clk), .rst(rst), .ser_rx(ser_rx), .ser_tx(ser_tx), .reg_cmd(reg_cmd),
  .reg_rdata(reg_rdata), .reg_ack(reg_ack), .pkt_drop(pkt_drop));

// ==== sim/scp_host_model.sv ====
/*
  Host side of the serial link: sends and receives 8N1 bytes.
  Assumes the design clock and the package bit timing.
*/
`timescale 1ns/1ps
module scp_host_model #(
  parameter int BIT_CYC = scp_pkg::BIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic ser_tx,
  output      logic ser_rx
);
  // line idles high; host only talks when the bench starts a packet
  initial ser_rx = 1'b1;

  // start bit, eight data bits lsb first, stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk) ser_rx <= f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask : send_byte

  logic [7:0] rx_q [$];   // bytes seen on the device transmit line
  logic       ok_q [$];   // stop level seen high for each of them

  // receiver runs all the time: a reply may start during our own stop bit
  always begin : rx_mon
    logic [7:0] b;
    @(posedge core_clk);
    if (ser_tx === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        b[i] = ser_tx;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      rx_q.push_back(b);
      ok_q.push_back(ser_tx === 1'b1);
    end
  end

  // hands over the next byte seen, gives up after a bound
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    while (rx_q.size() == 0 && n < 64 * BIT_CYC) begin
      @(posedge core_clk);
      n++;
    end
    if (rx_q.size() == 0) return;
    b = rx_q.pop_front();
    ok = ok_q.pop_front();
  endtask : recv_byte
endmodule : scp_host_model

// ==== sim/scp_cmd_tb.sv ====
/*
  Self-checking bench of the command interpreter: host model on the
  link, a register side answering each byte. Assumes the package clock, not its bit time.
*/
`timescale 1ns/1ps
module scp_cmd_tb;
  localparam logic [63:0] ADDR = 64'h0000_0002_0000_0200;
  localparam int          BIT  = 24;   // short bit time keeps the run brief
  typedef struct {
    logic [15:0] flags;
    logic [15:0] cmd;
    int          n;
    int          mode;   // 0 good, 1/3 bad packet/header check, 2 channel, 4 flags
    bit          resp;
  } scp_row_s;
  logic                  core_clk, rst, ser_rx, ser_tx, reg_ack, pkt_drop;
  logic [7:0]            reg_rdata;
  logic [15:0]           seq;
  scp_pkg::scp_reg_cmd_s reg_cmd;
  int                    err_count, n_tests, acc_n, drop_n, pkt_i;
  scp_row_s rows [7] = '{'{16'h4001, 16'h0800, 4, 0, 1'b1}, '{16'h4001, 16'h0802, 4, 0, 1'b1},
    '{16'h0001, 16'h0802, 2, 0, 1'b0}, '{16'h4001, 16'h0800, 4, 1, 1'b0},
    '{16'h4001, 16'h0802, 4, 2, 1'b0}, '{16'h4001, 16'h0800, 4, 3, 1'b0},
    '{16'h2001, 16'h0802, 4, 4, 1'b0}};

  scp_cmd #(.MAX_DATA(16), .BIT_CYC(BIT)) dut_u (.core_clk(core_clk), .rst(rst),
    .ser_rx(ser_rx), .ser_tx(ser_tx), .reg_cmd(reg_cmd), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .pkt_drop(pkt_drop));
  scp_host_model #(.BIT_CYC(BIT)) host_u (.core_clk(core_clk), .ser_tx(ser_tx),
    .ser_rx(ser_rx));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // register side: acks every other cycle, data follows the byte index
  always @(posedge core_clk) begin
    if (rst) begin
      reg_ack   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_ack   <= reg_cmd.req && !reg_ack;
      reg_rdata <= 8'hC0 + reg_cmd.idx[7:0];
    end
    if (reg_cmd.req !== 1'b1) pkt_i = 0;
    if (reg_cmd.req === 1'b1 && reg_ack === 1'b1) begin
      check(reg_cmd.addr, ADDR);
      check(reg_cmd.idx, pkt_i);
      if (reg_cmd.we) check(reg_cmd.wdata, 8'h10 + pkt_i[7:0]);
      pkt_i++;
      acc_n++;
    end
    if (pkt_drop === 1'b1) drop_n++;
  end

  function automatic logic [15:0] crc_of(input logic [7:0] p [$], input int a, input int z);
    logic [15:0] c;
    c = scp_pkg::CRC_INIT;
    for (int i = a; i < z; i++) begin
      c = c ^ {p[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ scp_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_of

  task automatic make_pkt(input logic [15:0] flags, cmd, chan, input logic [7:0] ded [$],
                          output logic [7:0] p [$]);
    logic [15:0] c;
    p = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, chan[15:8], chan[7:0], flags[15:8],
      flags[7:0], cmd[15:8], cmd[7:0], 8'h00, 8'(ded.size()), seq[15:8], seq[7:0]};
    p = {p, ded};
    c = crc_of(p, 6, 16);
    p[2] = c[15:8];
    p[3] = c[7:0];
    c = crc_of(p, 6, p.size());
    p[4] = c[15:8];
    p[5] = c[7:0];
  endtask : make_pkt

  task automatic run_row(input scp_row_s r);
    logic [7:0] ded [$];
    logic [7:0] p [$];
    logic [7:0] e [$];
    logic [7:0] b;
    logic       ok;
    int         d0, lo, a0;
    for (int i = 0; i < 8; i++) ded.push_back(ADDR[8*(7-i) +: 8]);
    if (r.cmd == 16'h0800) begin
      ded = {ded, 8'h00, 8'h00, 8'h00, 8'(r.n)};
      for (int i = 0; i < r.n; i++) e.push_back(8'hC0 + 8'(i));
    end else begin
      for (int i = 0; i < r.n; i++) ded.push_back(8'h10 + 8'(i));
      e = {8'h00, 8'h00, 8'h00, 8'h00};
    end
    make_pkt(r.flags, r.cmd, (r.mode == 2) ? 16'h0001 : 16'h0000, ded, p);
    if (r.mode == 1) p[5] = ~p[5];
    if (r.mode == 3) p[3] = ~p[3];
    a0 = acc_n;
    d0 = drop_n;
    foreach (p[i]) host_u.send_byte(p[i]);
    if (r.resp) begin
      make_pkt(16'h0000, r.cmd | 16'h0001, 16'h0000, e, p);
      foreach (p[i]) begin
        host_u.recv_byte(b, ok);
        check(ok, 1'b1);
        check(b, p[i]);
      end
    end else begin
      lo = 0;
      repeat (20 * BIT) @(posedge core_clk) if (ser_tx !== 1'b1) lo++;
      check(lo, 0);
    end
    check(acc_n - a0, (r.mode != 0) ? 0 : r.n);
    check(drop_n - d0, r.mode != 0);
    seq++;
  endtask : run_row

  // bound on the whole run, 340 byte times, a little above the about 295 expected
  initial begin
    repeat (3400 * BIT) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    seq = 16'h0001;
    repeat (4) @(posedge core_clk);
    check(ser_tx, 1'b1);
    check(reg_cmd.req, 1'b0);
    check(pkt_drop, 1'b0);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    foreach (rows[i]) run_row(rows[i]);
    // broken prefixes ahead of a good read: search restarts silently
    host_u.send_byte(8'h55);
    host_u.send_byte(8'h01);
    host_u.send_byte(8'h05);
    run_row(rows[0]);
    report_and_stop();
  end
endmodule : scp_cmd_tb
